//--- inc/scc_pkg.sv
// constants and types shared by the system clock control block
package scc_pkg;

	// register byte offsets on the special function register port
	localparam logic [7:0] OFS_POWER_CTRL   = 8'h87;
	localparam logic [7:0] OFS_SOURCE_CTRL  = 8'h91;
	localparam logic [7:0] OFS_GATE_CTRL    = 8'h92;
	localparam logic [7:0] OFS_OSC_CMD      = 8'h93;
	localparam logic [7:0] OFS_SYS_DIVISOR  = 8'h94;

	// processor_power_control fields
	localparam int PWR_IDLE_BIT = 0;
	localparam int PWR_GUARD_BIT = 1;

	// clock_source_control fields
	localparam int SRC_DIV_EN_BIT  = 0;
	localparam int SRC_SEL_BIT     = 1;
	localparam int SRC_PLL_SEL_BIT = 2;
	localparam int SRC_PLL_EN_BIT  = 4;
	localparam int SRC_LOWPWR_BIT  = 5;
	localparam logic [7:0] SRC_WR_MASK = 8'h37;

	// clock_gate_control fields
	localparam int GATE_USB_BIT    = 0;
	localparam int GATE_TIMER_BIT  = 1;
	localparam int GATE_PERIPH_BIT = 3;
	localparam int GATE_MISC_BIT   = 4;
	localparam int GATE_WAKE_BIT   = 5;
	localparam int GATE_SLOW_BIT   = 6;
	localparam int GATE_FIFO_BIT   = 7;
	localparam logic [7:0] GATE_WR_MASK = 8'hfb;

	// oscillator_command_status read fields
	localparam int OSC_FAST_ACT_BIT = 0;
	localparam int OSC_SLOW_ACT_BIT = 1;
	localparam int OSC_STABLE_BIT   = 2;

	// reset values
	localparam logic [7:0] RST_POWER_CTRL  = 8'h00;
	localparam logic [7:0] RST_SOURCE_CTRL = 8'h00;
	localparam logic [7:0] RST_GATE_CTRL   = 8'h1e;
	localparam logic [7:0] RST_SYS_DIVISOR = 8'h00;
	localparam logic [2:0] RST_OSC_STATUS  = 3'h5;

	// oscillator command keywords, each followed by its inverse
	localparam logic [7:0] KEY_FAST_STOP   = 8'haa;
	localparam logic [7:0] KEY_FAST_RESUME = 8'h3c;
	localparam logic [7:0] KEY_SLOW_STOP   = 8'hf0;
	localparam logic [7:0] KEY_SLOW_RESUME = 8'h66;

	// stall lengths in source or divided clock periods
	localparam logic [1:0] SWITCH_STALL_PERIODS = 2'h2;
	localparam logic [1:0] DIV_STALL_PERIODS    = 2'h2;

	// timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int OSC_SETTLE_MS = 16;
	localparam int OSC_SETTLE_CYCLES = OSC_SETTLE_MS * 1000000 / CLK_PERIOD_NS;

	// system clock sequencer states
	typedef enum logic [1:0] {
		SEQ_RUN    = 2'b00,
		SEQ_SWITCH = 2'b01,
		SEQ_DIVACT = 2'b10
	} scc_seq_type;

	// six gated clock domains
	typedef struct packed {
		logic cpu;
		logic timer;
		logic periph;
		logic usb;
		logic fifo;
		logic misc;
	} scc_domain_type;

	// register bus request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} scc_bus_type;

endpackage

//--- hdl/scc_clock_ctrl.sv
// system clock control: source select, divider, domain gating, oscillator commands
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/10ps

module scc_clock_ctrl
	import scc_pkg::*;
#(
	parameter int SETTLE_CYCLES = OSC_SETTLE_CYCLES
) (
	input  wire logic           mclk,
	input  wire logic           rst_n,
	input  wire logic [7:0]     sfr_addr,
	input  wire logic [7:0]     sfr_wdata,
	input  wire logic           sfr_wr,
	input  wire logic           sfr_rd,
	output logic [7:0]          sfr_rdata,
	input  wire logic           fast_osc_in,
	input  wire logic           slow_osc_in,
	input  wire logic           cpu_wake,
	output logic                fast_osc_run,
	output logic                slow_osc_run,
	output logic                slow_osc_low_power,
	output logic                pll_run,
	output logic                sys_clk,
	output scc_domain_type      domain_clk,
	output logic                slow_clk_gated,
	output logic                wakeup_clk
);

	////////////////////////////////////////////////////////////////////////////////
	// elaboration check and bus bundling

	if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 32'h0fffffff) begin : g_bad_settle
		$error("SETTLE_CYCLES out of range");
	end

	scc_bus_type bus;
	assign bus = '{addr: sfr_addr, wdata: sfr_wdata, wr: sfr_wr, rd: sfr_rd};

	////////////////////////////////////////////////////////////////////////////////
	// oscillator pin synchronisers: the first stage feeds only the second

	logic [2:0] fast_sync_reg;
	logic [2:0] fast_sync_next;
	logic [2:0] slow_sync_reg;
	logic [2:0] slow_sync_next;
	logic       fast_rise;
	logic       fast_edge;
	logic       slow_rise;
	logic       src_rise;

	// stage 2 vs stage 3 gives edges
	always_comb begin
		fast_sync_next = {fast_sync_reg[1:0], fast_osc_in};
		slow_sync_next = {slow_sync_reg[1:0], slow_osc_in};
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			fast_sync_reg <= 3'h0;
			slow_sync_reg <= 3'h0;
		end else begin
			fast_sync_reg <= fast_sync_next;
			slow_sync_reg <= slow_sync_next;
		end
	end

	assign fast_rise = fast_sync_reg[1] & ~fast_sync_reg[2];
	assign fast_edge = fast_sync_reg[1] ^ fast_sync_reg[2];
	assign slow_rise = slow_sync_reg[1] & ~slow_sync_reg[2];

	////////////////////////////////////////////////////////////////////////////////
	// software registers and oscillator command sequencer

	logic [7:0]  pwr_reg;
	logic [7:0]  pwr_next;
	logic [7:0]  src_reg;
	logic [7:0]  src_next;
	logic [7:0]  gate_reg;
	logic [7:0]  gate_next;
	logic [7:0]  div_reg;
	logic [7:0]  div_next;
	logic [7:0]  key_reg;
	logic [7:0]  key_next;
	logic        armed_reg;
	logic        armed_next;
	logic        fast_run_reg;
	logic        fast_run_next;
	logic        slow_run_reg;
	logic        slow_run_next;
	logic [2:0]  stat_reg;
	logic [2:0]  stat_next;
	logic [31:0] settle_reg;
	logic [31:0] settle_next;
	logic [7:0]  rdata_reg;
	logic [7:0]  rdata_next;
	logic        cur_sel_reg;
	logic        cur_pll_reg;
	logic        wr_cmd;
	logic        fast_feeds_sys;
	logic        slow_feeds_sys;

	assign wr_cmd = bus.wr && bus.addr == OFS_OSC_CMD;
	// the pll runs off the fast crystal, so both fast paths depend on it
	assign fast_feeds_sys = ~cur_sel_reg;
	assign slow_feeds_sys = cur_sel_reg;

	always_comb begin
		pwr_next      = pwr_reg;
		src_next      = src_reg;
		gate_next     = gate_reg;
		div_next      = div_reg;
		key_next      = key_reg;
		armed_next    = 1'b0;
		fast_run_next = fast_run_reg;
		slow_run_next = slow_run_reg;
		stat_next     = stat_reg;
		settle_next   = settle_reg;
		rdata_next    = 8'h00;
		// plain register writes
		if (bus.wr) begin
			case (bus.addr)
				OFS_POWER_CTRL: begin
					pwr_next = {6'h00, bus.wdata[PWR_GUARD_BIT], bus.wdata[PWR_IDLE_BIT]};
				end
				OFS_SOURCE_CTRL: begin
					src_next = bus.wdata & SRC_WR_MASK;
				end
				OFS_GATE_CTRL: begin
					gate_next = bus.wdata & GATE_WR_MASK;
				end
				OFS_SYS_DIVISOR: begin
					div_next = bus.wdata;
				end
				default: begin
				end
			endcase
		end
		// wake from the interrupt logic ends idle and wins over a write
		if (cpu_wake) begin
			pwr_next[PWR_IDLE_BIT] = 1'b0;
		end
		// count down before the commands so a resume below restarts the full settle time
		if (settle_reg != 32'h0) begin
			settle_next = settle_reg - 32'h1;
			if (settle_reg == 32'h1) begin
				stat_next[OSC_STABLE_BIT] = 1'b1;
			end
		end
		// keyword pairs; a write to any other register breaks the pair
		if (wr_cmd && !armed_reg) begin
			key_next = bus.wdata;
			armed_next = bus.wdata == KEY_FAST_STOP || bus.wdata == KEY_FAST_RESUME ||
				bus.wdata == KEY_SLOW_STOP || bus.wdata == KEY_SLOW_RESUME;
		end else if (wr_cmd && armed_reg && bus.wdata == ~key_reg) begin
			case (key_reg)
				KEY_FAST_STOP: begin
					if (pwr_reg[PWR_GUARD_BIT] || !fast_feeds_sys) begin
						fast_run_next = 1'b0;
					end
				end
				KEY_FAST_RESUME: begin
					if (!fast_run_reg) begin
						fast_run_next = 1'b1;
						stat_next[OSC_STABLE_BIT] = 1'b0;
						settle_next = 32'(SETTLE_CYCLES);
					end
				end
				KEY_SLOW_STOP: begin
					if (pwr_reg[PWR_GUARD_BIT] || !slow_feeds_sys) begin
						slow_run_next = 1'b0;
					end
				end
				KEY_SLOW_RESUME: begin
					if (!slow_run_reg) begin
						slow_run_next = 1'b1;
						stat_next[OSC_STABLE_BIT] = 1'b0;
						settle_next = 32'(SETTLE_CYCLES);
					end
				end
				default: begin
				end
			endcase
		end
		// a stop shows on the active flag one cycle later; a resume only once settled
		if (!fast_run_reg) begin
			stat_next[OSC_FAST_ACT_BIT] = 1'b0;
		end else if (stat_next[OSC_STABLE_BIT]) begin
			stat_next[OSC_FAST_ACT_BIT] = 1'b1;
		end
		if (!slow_run_reg) begin
			stat_next[OSC_SLOW_ACT_BIT] = 1'b0;
		end else if (stat_next[OSC_STABLE_BIT]) begin
			stat_next[OSC_SLOW_ACT_BIT] = 1'b1;
		end
		// read data in the following cycle; divisor is write-only
		if (bus.rd) begin
			case (bus.addr)
				OFS_POWER_CTRL: begin
					rdata_next = pwr_reg;
				end
				OFS_SOURCE_CTRL: begin
					rdata_next = src_reg;
				end
				OFS_GATE_CTRL: begin
					rdata_next = gate_reg;
				end
				OFS_OSC_CMD: begin
					rdata_next = {5'h00, stat_reg};
				end
				default: begin
					rdata_next = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pwr_reg      <= RST_POWER_CTRL;
			src_reg      <= RST_SOURCE_CTRL;
			gate_reg     <= RST_GATE_CTRL;
			div_reg      <= RST_SYS_DIVISOR;
			key_reg      <= 8'h00;
			armed_reg    <= 1'b0;
			fast_run_reg <= 1'b1;
			slow_run_reg <= 1'b0;
			stat_reg     <= RST_OSC_STATUS;
			settle_reg   <= 32'h0;
			rdata_reg    <= 8'h00;
		end else begin
			pwr_reg      <= pwr_next;
			src_reg      <= src_next;
			gate_reg     <= gate_next;
			div_reg      <= div_next;
			key_reg      <= key_next;
			armed_reg    <= armed_next;
			fast_run_reg <= fast_run_next;
			slow_run_reg <= slow_run_next;
			stat_reg     <= stat_next;
			settle_reg   <= settle_next;
			rdata_reg    <= rdata_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// system clock sequencer: source switch stall, divider, divider activation

	scc_seq_type seq_reg;
	scc_seq_type seq_next;
	logic        cur_sel_next;
	logic        cur_pll_next;
	logic        div_on_reg;
	logic        div_on_next;
	logic [1:0]  old_cnt_reg;
	logic [1:0]  old_cnt_next;
	logic [1:0]  new_cnt_reg;
	logic [1:0]  new_cnt_next;
	logic [7:0]  dcnt_reg;
	logic [7:0]  dcnt_next;
	logic        dclk_reg;
	logic        dclk_next;
	logic        sys_reg;
	logic        sys_next;
	logic        old_rise;
	logic        new_rise;
	logic        src_level;

	// with the pll each fast edge is one full system period
	assign src_rise  = cur_sel_reg ? slow_rise : (cur_pll_reg ? fast_edge : fast_rise);
	assign src_level = cur_sel_reg ? slow_sync_reg[1] :
		(cur_pll_reg ? fast_edge : fast_sync_reg[1]);
	assign old_rise  = src_rise;
	assign new_rise  = src_reg[SRC_SEL_BIT] ? slow_rise :
		(src_reg[SRC_PLL_SEL_BIT] ? fast_edge : fast_rise);

	always_comb begin
		seq_next     = seq_reg;
		cur_sel_next = cur_sel_reg;
		cur_pll_next = cur_pll_reg;
		div_on_next  = div_on_reg;
		old_cnt_next = old_cnt_reg;
		new_cnt_next = new_cnt_reg;
		dcnt_next    = dcnt_reg;
		dclk_next    = dclk_reg;
		sys_next     = sys_reg;
		// divided clock toggles every n+1 source periods
		if (src_rise) begin
			if (dcnt_reg >= div_reg) begin
				dcnt_next = 8'h00;
				dclk_next = ~dclk_reg;
			end else begin
				dcnt_next = dcnt_reg + 8'h01;
			end
		end
		case (seq_reg)
			SEQ_RUN: begin
				sys_next = div_on_reg ? dclk_reg : src_level;
				if (!src_reg[SRC_DIV_EN_BIT]) begin
					div_on_next = 1'b0;
				end
				if (src_reg[SRC_SEL_BIT] != cur_sel_reg ||
					(!src_reg[SRC_SEL_BIT] && src_reg[SRC_PLL_SEL_BIT] != cur_pll_reg)) begin
					seq_next = SEQ_SWITCH;
					sys_next = 1'b0;
					old_cnt_next = 2'h0;
					new_cnt_next = 2'h0;
				end else if (src_reg[SRC_DIV_EN_BIT] && !div_on_reg) begin
					seq_next = SEQ_DIVACT;
					sys_next = 1'b0;
					old_cnt_next = 2'h0;
					dcnt_next = 8'h00;
					dclk_next = 1'b0;
				end
			end
			SEQ_SWITCH: begin
				// both counts reaching two means the slower source ran two periods
				sys_next = 1'b0;
				if (old_rise && old_cnt_reg != SWITCH_STALL_PERIODS) begin
					old_cnt_next = old_cnt_reg + 2'h1;
				end
				if (new_rise && new_cnt_reg != SWITCH_STALL_PERIODS) begin
					new_cnt_next = new_cnt_reg + 2'h1;
				end
				// a dead target never counts up, so the clock stays halted
				if (old_cnt_reg == SWITCH_STALL_PERIODS &&
					new_cnt_reg == SWITCH_STALL_PERIODS) begin
					seq_next = SEQ_RUN;
					cur_sel_next = src_reg[SRC_SEL_BIT];
					cur_pll_next = src_reg[SRC_PLL_SEL_BIT];
					dcnt_next = 8'h00;
				end
			end
			SEQ_DIVACT: begin
				// count two divided rising edges with the output held low
				sys_next = 1'b0;
				if (src_rise && dcnt_reg >= div_reg && !dclk_reg) begin
					old_cnt_next = old_cnt_reg + 2'h1;
				end
				if (old_cnt_reg == DIV_STALL_PERIODS) begin
					seq_next = SEQ_RUN;
					div_on_next = 1'b1;
				end
			end
			default: begin
				seq_next = SEQ_RUN;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			seq_reg     <= SEQ_RUN;
			cur_sel_reg <= 1'b0;
			cur_pll_reg <= 1'b0;
			div_on_reg  <= 1'b0;
			old_cnt_reg <= 2'h0;
			new_cnt_reg <= 2'h0;
			dcnt_reg    <= 8'h00;
			dclk_reg    <= 1'b0;
			sys_reg     <= 1'b0;
		end else begin
			seq_reg     <= seq_next;
			cur_sel_reg <= cur_sel_next;
			cur_pll_reg <= cur_pll_next;
			div_on_reg  <= div_on_next;
			old_cnt_reg <= old_cnt_next;
			new_cnt_reg <= new_cnt_next;
			dcnt_reg    <= dcnt_next;
			dclk_reg    <= dclk_next;
			sys_reg     <= sys_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// domain gating: enables latch on the rising edge of the clock they gate

	scc_domain_type en_reg;
	scc_domain_type en_next;
	scc_domain_type dom_reg;
	scc_domain_type dom_next;
	logic           slow_en_reg;
	logic           slow_en_next;
	logic           wake_en_reg;
	logic           wake_en_next;
	logic           slow_out_reg;
	logic           slow_out_next;
	logic           wake_out_reg;
	logic           wake_out_next;
	logic           sys_rise;

	assign sys_rise = sys_next & ~sys_reg;

	always_comb begin
		en_next      = en_reg;
		slow_en_next = slow_en_reg;
		wake_en_next = wake_en_reg;
		if (sys_rise) begin
			en_next.cpu    = ~pwr_reg[PWR_IDLE_BIT];
			en_next.timer  = gate_reg[GATE_TIMER_BIT];
			en_next.periph = gate_reg[GATE_PERIPH_BIT];
			en_next.usb    = gate_reg[GATE_USB_BIT];
			en_next.fifo   = gate_reg[GATE_FIFO_BIT];
			en_next.misc   = gate_reg[GATE_MISC_BIT];
		end
		// the slow and wakeup gates follow the slow clock's own edge
		if (slow_rise) begin
			slow_en_next = gate_reg[GATE_SLOW_BIT];
			wake_en_next = gate_reg[GATE_WAKE_BIT];
		end
		// sampled enable during the high phase avoids glitches from mid-cycle writes
		dom_next      = sys_next ? en_next : '0;
		slow_out_next = slow_sync_reg[1] & slow_en_next;
		wake_out_next = slow_sync_reg[1] & wake_en_next;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			en_reg       <= '{cpu: 1'b1, timer: 1'b1, periph: 1'b1, usb: 1'b0,
				fifo: 1'b0, misc: 1'b1};
			dom_reg      <= '0;
			slow_en_reg  <= 1'b0;
			wake_en_reg  <= 1'b0;
			slow_out_reg <= 1'b0;
			wake_out_reg <= 1'b0;
		end else begin
			en_reg       <= en_next;
			dom_reg      <= dom_next;
			slow_en_reg  <= slow_en_next;
			wake_en_reg  <= wake_en_next;
			slow_out_reg <= slow_out_next;
			wake_out_reg <= wake_out_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs, all from flip-flops

	assign sfr_rdata          = rdata_reg;
	assign fast_osc_run       = fast_run_reg;
	assign slow_osc_run       = slow_run_reg;
	assign slow_osc_low_power = src_reg[SRC_LOWPWR_BIT];
	assign pll_run            = src_reg[SRC_PLL_EN_BIT];
	assign sys_clk            = sys_reg;
	assign domain_clk         = dom_reg;
	assign slow_clk_gated     = slow_out_reg;
	assign wakeup_clk         = wake_out_reg;

endmodule

//--- dv/scc_clock_ctrl_props.sv
// assertion checker for the system clock control block
`timescale 1ns/10ps

module scc_clock_ctrl_props
	import scc_pkg::*;
#(
	parameter int SETTLE_CYCLES = 20
) (
	input wire logic           mclk,
	input wire logic           rst_n,
	input wire logic [7:0]     sfr_addr,
	input wire logic [7:0]     sfr_wdata,
	input wire logic           sfr_wr,
	input wire logic           sfr_rd,
	input wire logic [7:0]     sfr_rdata,
	input wire logic           fast_osc_run,
	input wire logic           slow_osc_run,
	input wire logic           slow_osc_low_power,
	input wire logic           pll_run,
	input wire logic           sys_clk,
	input wire scc_domain_type domain_clk
);
	logic guard_reg;
	logic guard_next;
	logic sel_reg;
	logic sel_next;
	logic div_reg;
	logic div_next;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	////////////////////////////////////////////////////////////////////////////////
	// shadow of guard, select and divider bits, rebuilt from bus writes only
	always_comb begin
		guard_next = guard_reg;
		sel_next = sel_reg;
		div_next = div_reg;
		if (sfr_wr && sfr_addr == OFS_POWER_CTRL) guard_next = sfr_wdata[PWR_GUARD_BIT];
		if (sfr_wr && sfr_addr == OFS_SOURCE_CTRL) begin
			sel_next = sfr_wdata[SRC_SEL_BIT];
			div_next = sfr_wdata[SRC_DIV_EN_BIT];
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			guard_reg <= 1'b0;
			sel_reg <= 1'b0;
			div_reg <= 1'b0;
		end else begin
			guard_reg <= guard_next;
			sel_reg <= sel_next;
			div_reg <= div_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// a command is a keyword write and then its inverse on the very next cycle
	sequence s_key(logic [7:0] k);
		sfr_wr && sfr_addr == OFS_OSC_CMD && sfr_wdata == k;
	endsequence
	sequence s_pair(logic [7:0] k);
		s_key(k) ##1 s_key(~k);
	endsequence
	sequence s_src_wr;
		sfr_wr && sfr_addr == OFS_SOURCE_CTRL;
	endsequence

	property p_rdata_idle;
		sfr_rdata != 8'h00 |-> $past(sfr_rd);
	endproperty
	property p_status_read;
		sfr_rd && sfr_addr == OFS_OSC_CMD |=> sfr_rdata[7:3] == 5'h00;
	endproperty
	property p_fast_stop;
		s_pair(KEY_FAST_STOP) ##0 (guard_reg || sel_reg) |=> !fast_osc_run;
	endproperty
	property p_fast_guard;
		s_pair(KEY_FAST_STOP) ##0 (!guard_reg && !sel_reg) |=> $stable(fast_osc_run);
	endproperty
	property p_slow_stop;
		s_pair(KEY_SLOW_STOP) ##0 (guard_reg || !sel_reg) |=> !slow_osc_run;
	endproperty
	property p_fast_resume;
		s_pair(KEY_FAST_RESUME) |=> fast_osc_run;
	endproperty
	property p_slow_resume;
		s_pair(KEY_SLOW_RESUME) |=> slow_osc_run;
	endproperty
	property p_bad_pair;
		s_key(KEY_FAST_STOP) ##1 (sfr_wr && sfr_addr == OFS_OSC_CMD && sfr_wdata != ~KEY_FAST_STOP)
			|=> $stable(fast_osc_run) && $stable(slow_osc_run);
	endproperty
	property p_pll_bits;
		logic [7:0] d;
		(s_src_wr, d = sfr_wdata) |=>
			pll_run == d[SRC_PLL_EN_BIT] && slow_osc_low_power == d[SRC_LOWPWR_BIT];
	endproperty
	property p_switch_stall;
		// the sequencer sees the new bits one edge after the write lands
		s_src_wr ##0 (sfr_wdata[SRC_SEL_BIT] != sel_reg) |=> ##1 !sys_clk [*3];
	endproperty
	property p_div_stall;
		s_src_wr ##0 (sfr_wdata[SRC_DIV_EN_BIT] && !div_reg) |=> ##1 !sys_clk [*4];
	endproperty
	property p_domain_gated;
		domain_clk != 6'h00 |-> sys_clk;
	endproperty

	a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");
	a_status_read: assert property (p_status_read) else $error("status upper bits set");
	a_fast_stop: assert property (p_fast_stop) else $error("fast stop not taken");
	a_fast_guard: assert property (p_fast_guard) else $error("guard not kept");
	a_slow_stop: assert property (p_slow_stop) else $error("slow stop not taken");
	a_fast_resume: assert property (p_fast_resume) else $error("fast resume lost");
	a_slow_resume: assert property (p_slow_resume) else $error("slow resume lost");
	a_bad_pair: assert property (p_bad_pair) else $error("broken pair acted");
	a_pll_bits: assert property (p_pll_bits) else $error("pll or low power bit wrong");
	a_switch_stall: assert property (p_switch_stall) else $error("no switch stall");
	a_div_stall: assert property (p_div_stall) else $error("no divider stall");
	a_domain_gated: assert property (p_domain_gated) else $error("domain clock leak");
endmodule

bind scc_clock_ctrl scc_clock_ctrl_props #(
	.SETTLE_CYCLES(SETTLE_CYCLES)
) u_props (
	.mclk              (mclk),
	.rst_n             (rst_n),
	.sfr_addr          (sfr_addr),
	.sfr_wdata         (sfr_wdata),
	.sfr_wr            (sfr_wr),
	.sfr_rd            (sfr_rd),
	.sfr_rdata         (sfr_rdata),
	.fast_osc_run      (fast_osc_run),
	.slow_osc_run      (slow_osc_run),
	.slow_osc_low_power(slow_osc_low_power),
	.pll_run           (pll_run),
	.sys_clk           (sys_clk),
	.domain_clk        (domain_clk)
);

//--- dv/test_system_clock_control.sv
// self-checking testbench for the system clock control block
`timescale 1ns/10ps

module test_system_clock_control
	import scc_pkg::*;
;
	logic           mclk;
	logic           rst_n;
	logic [7:0]     sfr_addr;
	logic [7:0]     sfr_wdata;
	logic           sfr_wr;
	logic           sfr_rd;
	logic [7:0]     sfr_rdata;
	logic           cpu_wake;
	logic           fast_run;
	logic           slow_run;
	logic           low_pwr;
	logic           pll_run;
	logic           sys_clk;
	scc_domain_type domain_clk;
	logic           slow_gated;
	logic           wake_clk;
	logic [31:0]    cyc;
	logic [31:0]    rise_at;
	logic [31:0]    per;
	logic           sc_q;
	int             err_total;
	int             n_checks;

	// crystals are taken from the cycle count: fast is mclk/4, slow is mclk/16
	scc_clock_ctrl #(
		.SETTLE_CYCLES(20)
	) uut (
		.mclk              (mclk),
		.rst_n             (rst_n),
		.sfr_addr          (sfr_addr),
		.sfr_wdata         (sfr_wdata),
		.sfr_wr            (sfr_wr),
		.sfr_rd            (sfr_rd),
		.sfr_rdata         (sfr_rdata),
		.fast_osc_in       (cyc[1]),
		.slow_osc_in       (cyc[3]),
		.cpu_wake          (cpu_wake),
		.fast_osc_run      (fast_run),
		.slow_osc_run      (slow_run),
		.slow_osc_low_power(low_pwr),
		.pll_run           (pll_run),
		.sys_clk           (sys_clk),
		.domain_clk        (domain_clk),
		.slow_clk_gated    (slow_gated),
		.wakeup_clk        (wake_clk)
	);

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	always @(posedge mclk) cyc <= cyc + 32'h1;

	// sys_clk period in mclk cycles, sampled on the falling edge to stay off the launch edge
	always @(negedge mclk) begin
		sc_q <= sys_clk;
		if (sys_clk && !sc_q) begin
			per <= cyc - rise_at;
			rise_at <= cyc;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// every bus task drives both strobes, so back-to-back calls never assign twice
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		sfr_rd <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic idle(input int n);
		sfr_wr <= 1'b0;
		sfr_rd <= 1'b0;
		repeat (n) @(posedge mclk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		sfr_addr <= a;
		sfr_wr <= 1'b0;
		sfr_rd <= 1'b1;
		@(posedge mclk);
		sfr_rd <= 1'b0;
		@(negedge mclk);
		chk(32'(sfr_rdata), 32'(exp));
		@(posedge mclk);
	endtask

	task automatic cmd(input logic [7:0] k1, input logic [7:0] k2);
		wr(OFS_OSC_CMD, k1);
		wr(OFS_OSC_CMD, k2);
		idle(1);
	endtask

	// gives the gates time to latch, then collects which domains and slow-clock outputs toggled
	task automatic seen(input logic [7:0] exp);
		logic [7:0] acc;
		acc = 8'h00;
		idle(12);
		repeat (40) begin
			@(negedge mclk);
			acc = acc | {wake_clk, slow_gated, domain_clk};
		end
		@(posedge mclk);
		chk(32'(acc), 32'(exp));
	endtask

	// long wait covers the stall of a switch or divider start
	task automatic pchk(input logic [31:0] exp);
		idle(300);
		chk(per, exp);
	endtask

	function automatic logic [7:0] dom(input logic [7:0] g);
		return {g[GATE_WAKE_BIT], g[GATE_SLOW_BIT], 1'b1, g[GATE_TIMER_BIT],
			g[GATE_PERIPH_BIT], g[GATE_USB_BIT],
			g[GATE_FIFO_BIT], g[GATE_MISC_BIT]};
	endfunction

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (10000) @(posedge mclk);
		err_total++;
		give_verdict();
	end

	initial begin
		logic [7:0] gates [5];
		gates = '{8'h00, 8'h91, 8'h0a, 8'hfb, 8'h1e};
		err_total = 0;
		n_checks = 0;
		cyc = 32'h0;
		rise_at = 32'h0;
		per = 32'h0;
		sc_q = 1'b0;
		rst_n = 1'b0;
		sfr_addr = 8'h00;
		sfr_wdata = 8'h00;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		cpu_wake = 1'b0;
		repeat (6) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		chk(32'({fast_run, slow_run, pll_run, low_pwr}), 32'h8);
		rd(OFS_POWER_CTRL, RST_POWER_CTRL);
		rd(OFS_SOURCE_CTRL, RST_SOURCE_CTRL);
		rd(OFS_GATE_CTRL, RST_GATE_CTRL);
		rd(OFS_OSC_CMD, {5'h00, RST_OSC_STATUS});
		rd(OFS_SYS_DIVISOR, 8'h00);
		rd(8'h95, 8'h00);
		wr(OFS_SOURCE_CTRL, 8'h30);
		idle(1);
		chk(32'({pll_run, low_pwr}), 32'h3);
		rd(OFS_SOURCE_CTRL, 8'h30);
		wr(OFS_SOURCE_CTRL, 8'h00);
		// the gate register has no cpu bit, so the cpu domain is expected on: only idle stops that domain
		foreach (gates[i]) begin
			wr(OFS_GATE_CTRL, gates[i]);
			seen(dom(gates[i]));
			rd(OFS_GATE_CTRL, gates[i] & GATE_WR_MASK);
		end
		wr(OFS_POWER_CTRL, 8'h01);
		seen(8'h19);
		cpu_wake <= 1'b1;
		@(posedge mclk);
		cpu_wake <= 1'b0;
		seen(8'h39);
		cmd(KEY_FAST_STOP, ~KEY_FAST_STOP);
		chk(32'(fast_run), 32'h1);
		wr(OFS_POWER_CTRL, 8'h02);
		cmd(KEY_FAST_STOP, 8'h54);
		cmd(8'h12, 8'hed);
		chk(32'({fast_run, slow_run}), 32'h2);
		cmd(KEY_FAST_STOP, ~KEY_FAST_STOP);
		chk(32'(fast_run), 32'h0);
		rd(OFS_OSC_CMD, 8'h04);
		cmd(KEY_FAST_RESUME, ~KEY_FAST_RESUME);
		chk(32'(fast_run), 32'h1);
		rd(OFS_OSC_CMD, 8'h00);
		idle(40);
		rd(OFS_OSC_CMD, 8'h05);
		cmd(KEY_SLOW_RESUME, ~KEY_SLOW_RESUME);
		chk(32'(slow_run), 32'h1);
		idle(40);
		rd(OFS_OSC_CMD, 8'h07);
		wr(OFS_GATE_CTRL, 8'h5e);
		// divider first, ratio afterwards, keeps the start-up stall short
		wr(OFS_SOURCE_CTRL, 8'h01);
		for (int n = 0; n < 3; n++) begin
			wr(OFS_SYS_DIVISOR, 8'(n));
			pchk(32'(8 * (n + 1)));
		end
		wr(OFS_SOURCE_CTRL, 8'h02);
		pchk(32'h10);
		wr(OFS_POWER_CTRL, 8'h00);
		cmd(KEY_SLOW_STOP, ~KEY_SLOW_STOP);
		cmd(KEY_FAST_STOP, ~KEY_FAST_STOP);
		chk(32'({fast_run, slow_run}), 32'h1);
		cmd(KEY_FAST_RESUME, ~KEY_FAST_RESUME);
		idle(40);
		wr(OFS_SOURCE_CTRL, 8'h14);
		pchk(32'h2);
		wr(OFS_GATE_CTRL, 8'h1e);
		cmd(KEY_SLOW_STOP, ~KEY_SLOW_STOP);
		chk(32'(slow_run), 32'h0);
		give_verdict();
	end
endmodule
